/* hpb_device.sv */
`timescale 1ns/100ps
`default_nettype none
`include "hpb_defs.svh"
module hpb_device (
   input wire logic clk, // System clock
   input wire logic nrst, // Synchronous reset, low active
   hpb_if.dev bus, // Host pins
   output hpb_pkg::hpb_addr_t reg_addr, // Register address
   output logic reg_rd, // Register read pulse
   input wire hpb_pkg::hpb_data_t reg_rdata, // Read data, same cycle
   output logic reg_wr, // Register write pulse
   output hpb_pkg::hpb_data_t reg_wdata, // Register write data
   input wire logic dma_mode_en, // Shared pin is DMA grant
   output logic dma_grant, // Grant seen, level
   input wire logic rx_ready, // Receive data waiting
   input wire logic tx_need, // Transmit data wanted
   input wire logic dreq_rx_low, // Receive request active low
   input wire logic dreq_tx_low, // Transmit request active low
   input wire hpb_pkg::hpb_irq_cfg_e irq_cfg, // Interrupt pin style
   input wire logic irq_need, // Service wanted, level
   output logic irq_acked, // Acknowledge pulse
   output logic mux_mode // Last access was multiplexed
);
   import hpb_pkg::*;

   // ==========================================================
   // Strobe decode
   logic sel; // Chip selected
   logic rd_act; // Read access active
   logic wr_act; // Write access active
   logic rd_prev_r; // Read active last cycle
   logic wr_prev_r; // Write active last cycle
   logic rd_start; // First cycle of read
   logic wr_start; // First cycle of write
   logic wr_end; // Write strobe released

   // Access kind from style pin and strobes
   always_comb begin
      sel = !bus.cs_n;
      rd_act = 1'b0;
      wr_act = 1'b0;
      if (!bus.mode) begin
         // Separate strobes, read wins a clash
         rd_act = sel & !bus.rd_ds_n;
         wr_act = sel & !bus.wr_rw_n & bus.rd_ds_n;
      end else begin
         // Direction line qualified by data strobe
         rd_act = sel & !bus.rd_ds_n & bus.wr_rw_n;
         wr_act = sel & !bus.rd_ds_n & !bus.wr_rw_n;
      end
   end

   assign rd_start = rd_act & !rd_prev_r;
   assign wr_start = wr_act & !wr_prev_r;
   assign wr_end = wr_prev_r & !wr_act;

   // Previous strobe state for edge detection
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rd_prev_r <= 1'b0;
         wr_prev_r <= 1'b0;
      end else begin
         rd_prev_r <= rd_act;
         wr_prev_r <= wr_act;
      end
   end

   // ==========================================================
   // Address latch and address selection
   hpb_addr_t latch_r; // Held address from shared bus
   hpb_addr_t lat_addr; // Latch output, transparent
   hpb_addr_t cur_addr; // Address of starting access
   logic shared_bit; // Internal address bit four

   // Follow the shared bus while the latch strobe is high
   always_ff @(posedge clk) begin
      if (!nrst) begin
         latch_r <= `HPB_ADDR_RST;
      end else if (bus.ale) begin
         latch_r <= bus.host_data_bus[`HPB_AW-1:0];
      end
   end

   // Transparent while high, held after the fall
   assign lat_addr = bus.ale ? bus.host_data_bus[`HPB_AW-1:0]
                             : latch_r;

   // Bit four forced to zero in DMA mode
   assign shared_bit = dma_mode_en ? 1'b0 : bus.addr_bit_four_shared;

   // Source by bus arrangement sampled at access start
   always_comb begin
      if (!bus.ale) begin
         cur_addr = lat_addr;
      end else begin
         cur_addr = bus.host_addr_bus;
      end
      cur_addr[`HPB_SHARED_BIT] = shared_bit;
   end

   // Address held for the whole access
   always_ff @(posedge clk) begin
      if (!nrst) begin
         reg_addr <= `HPB_ADDR_RST;
         mux_mode <= 1'b0;
      end else if (rd_start || wr_start) begin
         reg_addr <= cur_addr;
         mux_mode <= !bus.ale;
      end
   end

   // ==========================================================
   // Read path
   hpb_data_t rdata_r; // Data presented on the bus
   logic oe_n_r; // Data pin enable

   // Read pulse one cycle after the strobe opens
   always_ff @(posedge clk) begin
      if (!nrst) begin
         reg_rd <= 1'b0;
      end else begin
         reg_rd <= rd_start;
      end
   end

   // Capture answer of the register file
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rdata_r <= `HPB_DATA_RST;
      end else if (reg_rd) begin
         rdata_r <= reg_rdata;
      end
   end

   // Drive for a selected read, one cycle behind the strobe
   always_ff @(posedge clk) begin
      if (!nrst) begin
         oe_n_r <= 1'b1;
      end else begin
         oe_n_r <= !rd_act;
      end
   end

   assign bus.hd_dev_o = rdata_r;
   assign bus.hd_dev_oe_n = oe_n_r;

   // ==========================================================
   // Write path
   // Bus sampled while the strobe is on; host keeps it valid
   always_ff @(posedge clk) begin
      if (!nrst) begin
         reg_wdata <= `HPB_DATA_RST;
      end else if (wr_act) begin
         reg_wdata <= bus.host_data_bus;
      end
   end

   // Write pulse when the strobe closes
   always_ff @(posedge clk) begin
      if (!nrst) begin
         reg_wr <= 1'b0;
      end else begin
         reg_wr <= wr_end;
      end
   end

   // ==========================================================
   // DMA requests and grant
   // Grant is active low on the shared pin
   always_ff @(posedge clk) begin
      if (!nrst) begin
         dma_grant <= 1'b0;
      end else begin
         dma_grant <= dma_mode_en & !bus.addr_bit_four_shared;
      end
   end

   // Receive request stage
   hpb_dreq u_dreq_rx (
      .clk(clk),
      .nrst(nrst),
      .req(rx_ready),
      .active_low(dreq_rx_low),
      .pin_r(bus.dma_rx_request)
   );

   // Transmit request stage
   hpb_dreq u_dreq_tx (
      .clk(clk),
      .nrst(nrst),
      .req(tx_need),
      .active_low(dreq_tx_low),
      .pin_r(bus.dma_tx_request)
   );

   // ==========================================================
   // Interrupt pin
   logic irq_o_r; // Interrupt drive value
   logic irq_oe_n_r; // Interrupt enable
   logic interrupt_ack_in_prev_r; // Acknowledge last cycle

   // Pin style from configuration; released in reset
   always_ff @(posedge clk) begin
      if (!nrst) begin
         irq_o_r <= 1'b1;
         irq_oe_n_r <= 1'b1;
      end else begin
         case (irq_cfg)
            HPB_IRQ_PP_HIGH: begin
               irq_o_r <= irq_need;
               irq_oe_n_r <= 1'b0;
            end
            HPB_IRQ_PP_LOW: begin
               irq_o_r <= !irq_need;
               irq_oe_n_r <= 1'b0;
            end
            HPB_IRQ_OD: begin
               // Pull low only, line shared with others
               irq_o_r <= 1'b0;
               irq_oe_n_r <= !irq_need;
            end
            default: begin
               irq_o_r <= 1'b1;
               irq_oe_n_r <= 1'b1;
            end
         endcase
      end
   end

   assign bus.irq_o = irq_o_r;
   assign bus.irq_oe_n = irq_oe_n_r;

   // Acknowledge falling edge becomes a pulse
   always_ff @(posedge clk) begin
      if (!nrst) begin
         interrupt_ack_in_prev_r <= 1'b1;
         irq_acked <= 1'b0;
      end else begin
         interrupt_ack_in_prev_r <= bus.interrupt_ack_in;
         irq_acked <= interrupt_ack_in_prev_r & !bus.interrupt_ack_in;
      end
   end
endmodule
`default_nettype wire

/* hpb_defs.svh */
`ifndef HPB_DEFS_SVH
`define HPB_DEFS_SVH
// ==========================================================
// Widths
`define HPB_AW 7
`define HPB_DW 8
`define HPB_SHARED_BIT 4
// ==========================================================
// Reset values
`define HPB_DATA_RST 8'h00
`define HPB_ADDR_RST 7'h00
`define HPB_BUS_PULL 8'hFF
// ==========================================================
// Timing: clock period and host strobe timing
`define HPB_CLK_PS 5000
`define HPB_STROBE_NS 20
`define HPB_STROBE_CYC \
   ((`HPB_STROBE_NS * 1000 + `HPB_CLK_PS - 1) / `HPB_CLK_PS)
`define HPB_CNT_W 4
`endif

/* hpb_pkg.sv */
`default_nettype none
package hpb_pkg;
   // Interrupt pin drive styles
   typedef enum logic [1:0] {
      HPB_IRQ_OD = 2'b00,
      HPB_IRQ_PP_HIGH = 2'b01,
      HPB_IRQ_PP_LOW = 2'b10
   } hpb_irq_cfg_e;
   // Host access sequencer states
   typedef enum logic [2:0] {
      HPB_ST_IDLE = 3'b000,
      HPB_ST_ALE_HI = 3'b001,
      HPB_ST_ALE_LO = 3'b010,
      HPB_ST_STROBE = 3'b011,
      HPB_ST_HOLD = 3'b100
   } hpb_state_e;
   typedef logic [6:0] hpb_addr_t;
   typedef logic [7:0] hpb_data_t;
endpackage
`default_nettype wire

/* hpb_if.sv */
`timescale 1ns/100ps
`default_nettype none
`include "hpb_defs.svh"
interface hpb_if;
   import hpb_pkg::*;
   logic cs_n; // Chip select, low active
   logic rd_ds_n; // Read strobe or data_strobe_n
   logic wr_rw_n; // Write strobe or direction (high read)
   logic ale; // Address latch strobe / bus mode
   logic mode; // Bus style: low separate strobes
   hpb_addr_t host_addr_bus; // Address pins, bit 4 unused
   logic addr_bit_four_shared; // Address bit 4 or DMA grant
   hpb_data_t hd_host_o; // Host data drive
   logic hd_host_oe_n; // Host data enable, low drives
   hpb_data_t hd_dev_o; // Device data drive
   logic hd_dev_oe_n; // Device data enable, low drives
   hpb_data_t host_data_bus; // Resolved data bus level
   logic dma_rx_request; // Receive DMA request
   logic dma_tx_request; // Transmit DMA request
   logic irq_o; // Interrupt drive value
   logic irq_oe_n; // Interrupt enable, low drives
   logic irq_out; // Resolved interrupt line, pulled up
   logic interrupt_ack_in; // Interrupt acknowledge, low active

   // Wire resolution with pull-up when nobody drives
   assign host_data_bus = !hd_dev_oe_n ? hd_dev_o :
                          (!hd_host_oe_n ? hd_host_o : `HPB_BUS_PULL);
   assign irq_out = !irq_oe_n ? irq_o : 1'b1;

   modport dev (
      input cs_n, rd_ds_n, wr_rw_n, ale, mode, host_addr_bus,
      input addr_bit_four_shared, host_data_bus, interrupt_ack_in,
      output hd_dev_o, hd_dev_oe_n, dma_rx_request, dma_tx_request,
      output irq_o, irq_oe_n
   );
   modport host (
      output cs_n, rd_ds_n, wr_rw_n, ale, mode, host_addr_bus,
      output addr_bit_four_shared, hd_host_o, hd_host_oe_n,
      output interrupt_ack_in,
      input host_data_bus, dma_rx_request, dma_tx_request, irq_out
   );
endinterface
`default_nettype wire

/* hpb_dreq.sv */
`timescale 1ns/100ps
`default_nettype none
`include "hpb_defs.svh"
module hpb_dreq (
   input wire logic clk, // System clock
   input wire logic nrst, // Synchronous reset, low active
   input wire logic req, // Request level, high asserted
   input wire logic active_low, // Pin polarity select
   output logic pin_r // Request pin
);
   import hpb_pkg::*;
   // ==========================================================
   // Polarity stage; pin low during reset
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pin_r <= 1'b0;
      end else begin
         pin_r <= req ^ active_low;
      end
   end
endmodule
`default_nettype wire

/* hpb_host.sv */
`timescale 1ns/100ps
`default_nettype none
`include "hpb_defs.svh"
module hpb_host (
   input wire logic clk, // System clock
   input wire logic nrst, // Synchronous reset, low active
   hpb_if.host bus, // Device pins
   input wire logic bus_style, // Low separate strobes
   input wire logic use_mux, // Multiplexed address/data
   input wire logic use_dma, // Shared pin carries grant
   input wire logic dma_grant_in, // Grant to drive, high
   input wire logic cmd_valid, // Access request
   output logic cmd_ready, // Idle, request taken
   input wire logic cmd_write, // High write
   input wire hpb_pkg::hpb_addr_t cmd_addr, // Register address
   input wire hpb_pkg::hpb_data_t cmd_wdata, // Write data
   output logic rsp_valid, // Access done pulse
   output hpb_pkg::hpb_data_t rsp_rdata, // Read data
   input wire logic ack_req, // Pulse acknowledge request
   output logic irq_level // Interrupt line level
);
   import hpb_pkg::*;
   localparam logic [`HPB_CNT_W-1:0] STB_LAST =
      `HPB_CNT_W'(`HPB_STROBE_CYC - 1);

   hpb_state_e st_r; // Sequencer state
   logic [`HPB_CNT_W-1:0] cnt_r; // Strobe width counter
   logic wr_r; // Current access is a write
   hpb_addr_t addr_r; // Current address
   hpb_data_t wdata_r; // Current write data
   logic cs_n_r; // Chip select
   logic stb_r; // Strobe on
   logic ale_r; // Latch strobe
   hpb_data_t ad_o_r; // Bus drive value
   logic ad_oe_n_r; // Bus drive enable
   logic interrupt_ack_in_r; // Acknowledge pin
   logic sync_r; // Interrupt line sample

   assign cmd_ready = (st_r == HPB_ST_IDLE);

   // ==========================================================
   // Access sequencer
   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_r <= HPB_ST_IDLE;
         cnt_r <= '0;
         wr_r <= 1'b0;
         addr_r <= `HPB_ADDR_RST;
         wdata_r <= `HPB_DATA_RST;
         cs_n_r <= 1'b1;
         stb_r <= 1'b0;
         ale_r <= 1'b1;
         ad_o_r <= `HPB_DATA_RST;
         ad_oe_n_r <= 1'b1;
         rsp_valid <= 1'b0;
         rsp_rdata <= `HPB_DATA_RST;
      end else begin
         rsp_valid <= 1'b0;
         case (st_r)
            HPB_ST_IDLE: begin
               ale_r <= !use_mux;
               if (cmd_valid) begin
                  wr_r <= cmd_write;
                  addr_r <= cmd_addr;
                  wdata_r <= cmd_wdata;
                  if (use_mux) begin
                     // Address phase on the shared bus
                     ale_r <= 1'b1;
                     ad_o_r <= {1'b0, cmd_addr};
                     ad_oe_n_r <= 1'b0;
                     st_r <= HPB_ST_ALE_HI;
                  end else begin
                     cs_n_r <= 1'b0;
                     stb_r <= 1'b1;
                     ad_o_r <= cmd_wdata;
                     ad_oe_n_r <= !cmd_write;
                     cnt_r <= '0;
                     st_r <= HPB_ST_STROBE;
                  end
               end
            end
            HPB_ST_ALE_HI: begin
               ale_r <= 1'b0;
               st_r <= HPB_ST_ALE_LO;
            end
            HPB_ST_ALE_LO: begin
               cs_n_r <= 1'b0;
               stb_r <= 1'b1;
               ad_o_r <= wdata_r;
               ad_oe_n_r <= !wr_r;
               cnt_r <= '0;
               st_r <= HPB_ST_STROBE;
            end
            HPB_ST_STROBE: begin
               if (cnt_r == STB_LAST) begin
                  stb_r <= 1'b0;
                  cs_n_r <= 1'b1;
                  if (!wr_r) begin
                     rsp_rdata <= bus.host_data_bus;
                  end
                  st_r <= HPB_ST_HOLD;
               end else begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
            HPB_ST_HOLD: begin
               // Data held one cycle past the strobe
               ad_oe_n_r <= 1'b1;
               rsp_valid <= 1'b1;
               st_r <= HPB_ST_IDLE;
            end
            default: begin
               st_r <= HPB_ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Pin mapping by bus style
   assign bus.mode = bus_style;
   assign bus.cs_n = cs_n_r;
   assign bus.ale = ale_r;
   assign bus.rd_ds_n = bus_style ? !stb_r : !(stb_r & !wr_r);
   assign bus.wr_rw_n = bus_style ? !(wr_r & st_r != HPB_ST_IDLE)
                                  : !(stb_r & wr_r);
   assign bus.host_addr_bus = addr_r;
   assign bus.addr_bit_four_shared = use_dma ? !dma_grant_in
                                     : addr_r[`HPB_SHARED_BIT];
   assign bus.hd_host_o = ad_o_r;
   assign bus.hd_host_oe_n = ad_oe_n_r;

   // ==========================================================
   // Interrupt acknowledge and line sample
   always_ff @(posedge clk) begin
      if (!nrst) begin
         interrupt_ack_in_r <= 1'b1;
         sync_r <= 1'b1;
         irq_level <= 1'b1;
      end else begin
         interrupt_ack_in_r <= !ack_req;
         sync_r <= bus.irq_out;
         irq_level <= sync_r;
      end
   end

   assign bus.interrupt_ack_in = interrupt_ack_in_r;
endmodule
`default_nettype wire

/* hpb_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module hpb_chk (
   input wire logic clk, // System clock
   input wire logic nrst, // Sync reset, low active
   input wire logic cs_n, // Chip select
   input wire logic rd_ds_n, // Read or data strobe
   input wire logic wr_rw_n, // Write strobe or direction
   input wire logic ale, // Address latch strobe
   input wire logic mode, // Bus style
   input wire hpb_pkg::hpb_addr_t host_addr_bus, // Address pins
   input wire hpb_pkg::hpb_data_t host_data_bus, // Resolved data bus
   input wire logic hd_host_oe_n, // Host data enable
   input wire logic hd_dev_oe_n, // Device data enable
   input wire logic dma_rx_request, // Receive request pin
   input wire logic dma_tx_request, // Transmit request pin
   input wire logic irq_oe_n, // Interrupt enable
   input wire logic interrupt_ack_in // Acknowledge pin
);
   import hpb_pkg::*;
   // ==========================================================
   // Access decode
   logic rd_act; // Selected read in progress
   logic wr_act; // Selected write in progress
   logic acc; // Any selected access
   assign rd_act = !cs_n && !rd_ds_n && (mode ? wr_rw_n : 1'b1);
   assign wr_act = !cs_n && (mode ? (!rd_ds_n && !wr_rw_n)
                                  : (!wr_rw_n && rd_ds_n));
   assign acc = rd_act || wr_act;
   // ==========================================================
   // Sequences and assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   // Read strobe just opened
   sequence s_rd_open;
      !rd_act ##1 rd_act;
   endsequence
   // Read strobe held three samples
   sequence s_rd_held;
      rd_act [*3];
   endsequence
   chk_read_len: assert property (s_rd_open |-> s_rd_held)
      else $error("read strobe shorter than three cycles");
   chk_read_drive: assert property (s_rd_held |-> !hd_dev_oe_n)
      else $error("device not driving during read");
   chk_drive_cause: assert property (!hd_dev_oe_n |->
      rd_act || $past(rd_act) || $past(rd_act, 2))
      else $error("device drives data outside a read");
   chk_no_clash: assert property (hd_dev_oe_n || hd_host_oe_n)
      else $error("both ends drive the data bus");
   chk_wr_data: assert property (wr_act && $past(wr_act) |->
      $stable(host_data_bus) && !hd_host_oe_n)
      else $error("write data not held during strobe");
   chk_addr_hold: assert property (acc && $past(acc) |->
      $stable(ale) && (!ale || $stable(host_addr_bus)))
      else $error("address or bus mode moved in access");
   chk_reset_state: assert property ($rose(nrst) |-> hd_dev_oe_n &&
      irq_oe_n && !dma_rx_request && !dma_tx_request)
      else $error("pins not idle after reset");
   chk_read_data: assert property (s_rd_open ##1 s_rd_held |->
      $stable(host_data_bus))
      else $error("read data changed while strobe held");
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import hpb_pkg::*;
   logic clk, nrst; // Clock and sync reset
   logic reg_rd, reg_wr, dma_mode_en, dma_grant, rx_ready, tx_need;
   logic dreq_rx_low, dreq_tx_low, irq_need, irq_acked, mux_mode;
   logic bus_style, use_mux, use_dma, dma_grant_in, cmd_valid, cmd_ready;
   logic cmd_write, rsp_valid, ack_req, irq_level;
   hpb_addr_t reg_addr, cmd_addr, a; // Addresses
   hpb_data_t reg_rdata, reg_wdata, cmd_wdata, rsp_rdata, d; // Data
   hpb_irq_cfg_e irq_cfg; // Interrupt pin style
   hpb_data_t mem [128]; // Register file behind the device
   hpb_data_t shadow [128]; // Expected register contents
   logic [14:0] wr_q [$]; // Expected write address and data
   logic [8:0] rd_q [$]; // Expected read data, bit 8 marks a read
   int ack_exp, miscompares, samples_checked;
   hpb_if bus_if ();
   hpb_device i_hpb_device (.clk(clk), .nrst(nrst), .bus(bus_if.dev),
      .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .dma_mode_en(dma_mode_en),
      .dma_grant(dma_grant), .rx_ready(rx_ready), .tx_need(tx_need),
      .dreq_rx_low(dreq_rx_low), .dreq_tx_low(dreq_tx_low),
      .irq_cfg(irq_cfg), .irq_need(irq_need), .irq_acked(irq_acked),
      .mux_mode(mux_mode));
   hpb_host i_hpb_host (.clk(clk), .nrst(nrst), .bus(bus_if.host),
      .bus_style(bus_style), .use_mux(use_mux), .use_dma(use_dma),
      .dma_grant_in(dma_grant_in), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .ack_req(ack_req), .irq_level(irq_level));
   hpb_chk u_chk (.clk(clk), .nrst(nrst), .cs_n(bus_if.cs_n),
      .rd_ds_n(bus_if.rd_ds_n), .wr_rw_n(bus_if.wr_rw_n), .ale(bus_if.ale),
      .mode(bus_if.mode), .host_addr_bus(bus_if.host_addr_bus),
      .host_data_bus(bus_if.host_data_bus),
      .hd_host_oe_n(bus_if.hd_host_oe_n), .hd_dev_oe_n(bus_if.hd_dev_oe_n),
      .dma_rx_request(bus_if.dma_rx_request),
      .dma_tx_request(bus_if.dma_tx_request), .irq_oe_n(bus_if.irq_oe_n),
      .interrupt_ack_in(bus_if.interrupt_ack_in));
   // ==========================================================
   // Clock and register file
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   assign reg_rdata = mem[reg_addr];
   always @(posedge clk) begin
      if (reg_wr === 1'b1) begin
         mem[reg_addr] <= reg_wdata;
      end
   end
   // ==========================================================
   // Compare and report
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] s);
      samples_checked++;
      if (s !== e) begin
         miscompares++;
         $display("wrong value %s expected %0h seen %0h", nm, e, s);
      end
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Result watcher, oldest note first
   always @(posedge clk) begin
      if (reg_wr === 1'b1) begin
         chk("write pending", 1, wr_q.size() > 0);
         if (wr_q.size() > 0) begin
            chk("write", wr_q.pop_front(), {reg_addr, reg_wdata});
         end
      end
      if (reg_rd === 1'b1) begin
         chk("read pulse", 1, rd_q.size() > 0 && rd_q[0][8]);
      end
      if (rsp_valid === 1'b1) begin
         chk("response pending", 1, rd_q.size() > 0);
         if (rd_q.size() > 0 && rd_q[0][8]) begin
            chk("read data", rd_q[0][7:0], rsp_rdata);
         end
         if (rd_q.size() > 0) begin
            void'(rd_q.pop_front());
         end
      end
      if (irq_acked === 1'b1) begin
         chk("acknowledge", 1, ack_exp > 0);
         ack_exp--;
      end
   end
   // One host access, notes expected results when taken
   task automatic acc(input logic wr, input hpb_addr_t ad,
                      input hpb_data_t dt);
      int n;
      hpb_addr_t ea;
      ea = use_dma ? (ad & 7'h6F) : ad;
      n = 0;
      cmd_valid = 1'b1;
      cmd_write = wr;
      cmd_addr = ad;
      cmd_wdata = dt;
      while (cmd_ready !== 1'b1 && n < 50) begin
         @(negedge clk);
         n++;
      end
      if (wr) begin
         wr_q.push_back({ea, dt});
         shadow[ea] = dt;
      end
      rd_q.push_back(wr ? 9'h000 : {1'b1, shadow[ea]});
      @(negedge clk);
      cmd_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 50) begin
         @(negedge clk);
         n++;
      end
      chk("access done", 1, n < 50);
      @(negedge clk);
      chk("mux mode", use_mux, mux_mode);
   endtask
   // ==========================================================
   // Watchdog
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      give_verdict;
   end
   // ==========================================================
   // Main sequence
   initial begin
      {nrst, dma_mode_en, rx_ready, tx_need, irq_need} = '0;
      {dreq_rx_low, dreq_tx_low, bus_style, use_mux, use_dma} = '0;
      {dma_grant_in, cmd_valid, cmd_write, ack_req} = '0;
      {cmd_addr, cmd_wdata, ack_exp, miscompares, samples_checked} = '0;
      irq_cfg = HPB_IRQ_OD;
      for (int i = 0; i < 128; i++) begin
         mem[i] = 8'h00;
         shadow[i] = 8'h00;
      end
      void'($urandom(89786));
      repeat (8) @(negedge clk);
      nrst = 1'b1;
      @(negedge clk);
      chk("irq released", 1, bus_if.irq_oe_n);
      chk("rx pin", 0, bus_if.dma_rx_request);
      chk("tx pin", 0, bus_if.dma_tx_request);
      // Every strobe style, bus style and DMA setting
      for (int m = 0; m < 8; m++) begin
         bus_style = m[0];
         use_mux = m[1];
         use_dma = m[2];
         dma_mode_en = m[2];
         repeat (2) @(negedge clk);
         for (int k = 0; k < 6; k++) begin
            a = hpb_addr_t'($urandom_range(127));
            d = hpb_data_t'($urandom_range(255));
            acc(1'b1, a, d);
            acc(1'b0, a, 8'h00);
         end
      end
      // Grant seen only through the shared pin
      for (int g = 0; g < 2; g++) begin
         dma_grant_in = g[0];
         repeat (4) @(negedge clk);
         chk("dma grant", g[0], dma_grant);
      end
      {use_dma, dma_mode_en, dma_grant_in} = '0;
      // Request levels under both polarities
      for (int p = 0; p < 8; p++) begin
         rx_ready = p[0];
         tx_need = p[1];
         dreq_rx_low = p[2];
         dreq_tx_low = !p[2];
         repeat (3) @(negedge clk);
         chk("rx request", p[0] ^ p[2], bus_if.dma_rx_request);
         chk("tx request", p[1] ^ !p[2], bus_if.dma_tx_request);
      end
      // Interrupt pin styles with and without need
      for (int q = 0; q < 8; q++) begin
         irq_cfg = hpb_irq_cfg_e'(q[1:0]);
         irq_need = q[2];
         repeat (8) @(negedge clk);
         chk("irq line", q[1:0] == 2'b01 ? q[2] :
             (q[1:0] == 2'b11 ? 1'b1 : !q[2]), irq_level);
      end
      // Acknowledge pulses
      for (int r = 0; r < 2; r++) begin
         ack_exp++;
         ack_req = 1'b1;
         repeat (3) @(negedge clk);
         ack_req = 1'b0;
         repeat (4) @(negedge clk);
      end
      chk("notes left", 0, wr_q.size() + rd_q.size() + ack_exp);
      give_verdict;
   end
endmodule
`default_nettype wire
